/* File: rtl/rss_avmm_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module rss_avmm_slave
  import rss_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // bus request
  input wire logic i_read,
  input wire logic i_write,
  // handshake
  output logic o_waitrequest,
  output logic o_capture,
  output logic o_commit
);
  rss_bus_state_e state_q;

  // one wait cycle: data is captured on entry to ack, taken on leaving it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= RSS_BUS_WAIT;
    end
    else
    begin
      case (state_q)
        RSS_BUS_WAIT:
        begin
          if (i_read || i_write)
          begin
            state_q <= RSS_BUS_ACK;
          end
        end
        RSS_BUS_ACK:
        begin
          state_q <= RSS_BUS_WAIT;
        end
        default:
        begin
          state_q <= RSS_BUS_WAIT;
        end
      endcase
    end
  end

  // registered so the top output is a flop
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_waitrequest <= 1'b1;
    end
    else
    begin
      o_waitrequest <= !((state_q == RSS_BUS_WAIT) && (i_read || i_write));
    end
  end

  assign o_capture = (state_q == RSS_BUS_WAIT) && (i_read || i_write);
  assign o_commit = (state_q == RSS_BUS_ACK) && i_write;
endmodule // rss_avmm_slave
`default_nettype wire

/* File: rtl/rss_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
module rss_edge_det #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pins and edge pulses
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_edge
);
  logic [WIDTH-1:0] prev_q;
  logic primed_q;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("rss_edge_det needs at least one pin");
    end
  endgenerate

  // first cycle after reset only samples, so a pin held high is no edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      primed_q <= 1'b0;
    end
    else
    begin
      primed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      prev_q <= '0;
    end
    else
    begin
      prev_q <= i_pins;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_edge
      // rising or falling alike
      assign o_edge[gi] = primed_q & (prev_q[gi] ^ i_pins[gi]);
    end
  endgenerate
endmodule // rss_edge_det
`default_nettype wire

/* File: rtl/rss_pkg.sv */
// Contract
// - writing one to a low-six status bit clears it; writing zero leaves it.
// - either edge of edge_pin_a sets status bit 0, edge_pin_b sets bit 1.
// - either edge of edge_pin_c sets status bit 2, edge_pin_d sets bit 3.
// - either edge of edge_pin_e sets status bit 4, edge_pin_f sets bit 5.
// - status bits 7:6 are reserved and always read zero.
// - second uart fifo shadow: enable, rx clear, tx clear, dma, threshold 7:6.
// - force-change 1 clears on head_step_strobe_n AND drive_select_one_n.
// - force-change 0 clears on head_step_strobe_n AND drive_select_zero_n.
// - disk_changed_bit = (ds0 and fc0) or (ds1 and fc1) or disk_changed_in_n.
// - a set force-change flag shows disk change active when drive selected.
// - force register bit 0 drive 0, bit 1 drive 1, bits 7:2 read zero.
// - software writes of one set force flags; software never clears them.
// - rate shadow: rate 1:0, write_select_a 4:2, power down 6, reset 7.
package rss_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MISC_STATUS = 6'h1c;
  localparam logic [5:0] IDX_UART_B_SHADOW = 6'h1d;
  localparam logic [5:0] IDX_FORCE_CHANGE = 6'h1e;
  localparam logic [5:0] IDX_RATE_SHADOW = 6'h1f;
  localparam logic [5:0] IDX_UART_A_SHADOW = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h21;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h23;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // reset values
  localparam logic [7:0] RST_MISC_STATUS = 8'h00;
  localparam logic [7:0] RST_UART_SHADOW = 8'h00;
  localparam logic [7:0] RST_FORCE_CHANGE = 8'h03;
  localparam logic [7:0] RST_RATE_SHADOW = 8'h02;
  localparam logic [7:0] RST_IRQ = 8'h00;
  // field layout
  localparam int NUM_EDGE_PINS = 6;
  localparam logic [7:0] MISC_LIVE_MASK = 8'h3f;
  localparam logic [7:0] FORCE_LIVE_MASK = 8'h03;
  localparam logic [7:0] UART_SHADOW_MASK = 8'hcf;
  localparam logic [7:0] RATE_SHADOW_MASK = 8'hdf;
  localparam int FC_DRIVE0_BIT = 0;
  localparam int FC_DRIVE1_BIT = 1;
  localparam int IRQ_FC0_DONE_BIT = 6;
  localparam int IRQ_FC1_DONE_BIT = 7;
  // bus handshake states
  typedef enum logic [1:0] {
    RSS_BUS_WAIT = 2'b01,
    RSS_BUS_ACK = 2'b10
  } rss_bus_state_e;
endpackage

/* File: rtl/rss_regs.sv */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module rss_regs
  import rss_pkg::*;
#(
  parameter int EDGE_PINS = NUM_EDGE_PINS
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  // edge inputs
  input wire logic i_edge_pin_a,
  input wire logic i_edge_pin_b,
  input wire logic i_edge_pin_c,
  input wire logic i_edge_pin_d,
  input wire logic i_edge_pin_e,
  input wire logic i_edge_pin_f,
  // control register writes seen by the uarts and floppy core
  input wire logic i_uart_a_fcr_wr,
  input wire logic [REG_W-1:0] i_uart_a_fcr_data,
  input wire logic i_uart_b_fcr_wr,
  input wire logic [REG_W-1:0] i_uart_b_fcr_data,
  input wire logic i_rate_sel_wr,
  input wire logic [REG_W-1:0] i_rate_sel_data,
  // floppy drive terms
  input wire logic i_head_step_strobe_n,
  input wire logic i_drive_select_zero_n,
  input wire logic i_drive_select_one_n,
  input wire logic i_disk_changed_in_n,
  // results
  output logic o_disk_changed_bit,
  output logic [1:0] o_force_change,
  output logic o_irq
);
  localparam int NB = NUM_EDGE_PINS;

  generate
    if (EDGE_PINS != NB)
    begin : g_bad_pins
      $error("rss_regs serves exactly six edge pins");
    end
  endgenerate

  // bus handshake
  logic bus_capture;
  logic bus_commit;

  rss_avmm_slave u_bus (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_read(i_read),
    .i_write(i_write),
    .o_waitrequest(o_waitrequest),
    .o_capture(bus_capture),
    .o_commit(bus_commit)
  );

  // address decode; misaligned byte addresses map nowhere
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [5:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
  endfunction

  logic lane0_wr;
  logic [REG_W-1:0] wr_byte;

  // only byte lane 0 carries register bits
  assign lane0_wr = bus_commit && i_byteenable[0];
  assign wr_byte = i_writedata[REG_W-1:0];

  logic wr_misc;
  logic wr_force;
  logic wr_irq_en;
  logic wr_irq_clr;

  assign wr_misc = lane0_wr && hit(i_address, IDX_MISC_STATUS);
  assign wr_force = lane0_wr && hit(i_address, IDX_FORCE_CHANGE);
  assign wr_irq_en = lane0_wr && hit(i_address, IDX_IRQ_ENABLE);
  assign wr_irq_clr = lane0_wr && hit(i_address, IDX_IRQ_CLEAR);

  // edge detection
  logic [NB-1:0] pins;
  logic [NB-1:0] edges;

  assign pins = {i_edge_pin_f, i_edge_pin_e, i_edge_pin_d,
                 i_edge_pin_c, i_edge_pin_b, i_edge_pin_a};

  rss_edge_det #(
    .WIDTH(NB)
  ) u_edge (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(pins),
    .o_edge(edges)
  );

  // misc edge status
  logic [REG_W-1:0] misc_q;
  logic [REG_W-1:0] misc_d;
  logic [REG_W-1:0] edge_set;
  logic [REG_W-1:0] w1c_mask;

  // pin order places a..f on bits 0..5
  assign edge_set = {{(REG_W-NB){1'b0}}, edges};
  assign w1c_mask = wr_misc ? (wr_byte & MISC_LIVE_MASK) : '0;

  always_comb
  begin
    // clear first, then set, so a same-cycle edge survives
    misc_d = misc_q & ~w1c_mask;
    misc_d = misc_d | edge_set;
    misc_d = misc_d & MISC_LIVE_MASK;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      misc_q <= RST_MISC_STATUS;
    end
    else
    begin
      misc_q <= misc_d;
    end
  end

  // shadows of write-only control registers
  logic [REG_W-1:0] uart_a_shadow_q;
  logic [REG_W-1:0] uart_b_shadow_q;
  logic [REG_W-1:0] rate_shadow_q;

  // reserved bits 5:4 are dropped, layout as the control register
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      uart_a_shadow_q <= RST_UART_SHADOW;
    end
    else if (i_uart_a_fcr_wr)
    begin
      uart_a_shadow_q <= i_uart_a_fcr_data & UART_SHADOW_MASK;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      uart_b_shadow_q <= RST_UART_SHADOW;
    end
    else if (i_uart_b_fcr_wr)
    begin
      uart_b_shadow_q <= i_uart_b_fcr_data & UART_SHADOW_MASK;
    end
  end

  // bit 5 reserved, rest kept in place
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      rate_shadow_q <= RST_RATE_SHADOW;
    end
    else if (i_rate_sel_wr)
    begin
      rate_shadow_q <= i_rate_sel_data & RATE_SHADOW_MASK;
    end
  end

  // force disk change
  logic [1:0] force_q;
  logic [1:0] force_d;
  logic [1:0] step_clear;
  logic [1:0] sw_set;

  // literal and of the two strobe levels
  assign step_clear[FC_DRIVE0_BIT] = i_head_step_strobe_n &
                                     i_drive_select_zero_n;
  assign step_clear[FC_DRIVE1_BIT] = i_head_step_strobe_n &
                                     i_drive_select_one_n;
  assign sw_set = wr_force ? wr_byte[1:0] : 2'b00;

  always_comb
  begin
    // software only sets, and a set write beats a same-cycle step clear
    force_d = force_q & ~step_clear;
    force_d = force_d | sw_set;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      force_q <= RST_FORCE_CHANGE[1:0];
    end
    else
    begin
      force_q <= force_d;
    end
  end

  assign o_force_change = force_q;

  // disk change indication, one cycle behind the drive terms
  logic dskchg_d;

  assign dskchg_d = (i_drive_select_zero_n & force_q[FC_DRIVE0_BIT]) |
                    (i_drive_select_one_n & force_q[FC_DRIVE1_BIT]) |
                    i_disk_changed_in_n;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_disk_changed_bit <= 1'b0;
    end
    else
    begin
      o_disk_changed_bit <= dskchg_d;
    end
  end

  // interrupt status: edges plus force flags dropped by a step
  logic [REG_W-1:0] irq_sts_q;
  logic [REG_W-1:0] irq_sts_d;
  logic [REG_W-1:0] irq_en_q;
  logic [REG_W-1:0] irq_event;
  logic [1:0] fc_dropped;

  assign fc_dropped = force_q & ~force_d;

  always_comb
  begin
    irq_event = edge_set;
    irq_event[IRQ_FC0_DONE_BIT] = fc_dropped[FC_DRIVE0_BIT];
    irq_event[IRQ_FC1_DONE_BIT] = fc_dropped[FC_DRIVE1_BIT];
  end

  always_comb
  begin
    // set beats clear
    irq_sts_d = irq_sts_q;
    if (wr_irq_clr)
    begin
      irq_sts_d = irq_sts_d & ~wr_byte;
    end
    irq_sts_d = irq_sts_d | irq_event;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      irq_sts_q <= RST_IRQ;
    end
    else
    begin
      irq_sts_q <= irq_sts_d;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      irq_en_q <= RST_IRQ;
    end
    else if (wr_irq_en)
    begin
      irq_en_q <= wr_byte;
    end
  end

  // registered level; follows status with one cycle lag
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(irq_sts_q & irq_en_q);
    end
  end

  // read mux; unmapped and write-only locations read zero
  logic [REG_W-1:0] rd_byte;

  always_comb
  begin
    rd_byte = '0;
    if (hit(i_address, IDX_MISC_STATUS))
    begin
      rd_byte = misc_q & MISC_LIVE_MASK;
    end
    else if (hit(i_address, IDX_UART_B_SHADOW))
    begin
      rd_byte = uart_b_shadow_q;
    end
    else if (hit(i_address, IDX_FORCE_CHANGE))
    begin
      rd_byte = {6'h00, force_q} & FORCE_LIVE_MASK;
    end
    else if (hit(i_address, IDX_RATE_SHADOW))
    begin
      rd_byte = rate_shadow_q;
    end
    else if (hit(i_address, IDX_UART_A_SHADOW))
    begin
      rd_byte = uart_a_shadow_q;
    end
    else if (hit(i_address, IDX_IRQ_STATUS))
    begin
      rd_byte = irq_sts_q;
    end
    else if (hit(i_address, IDX_IRQ_ENABLE))
    begin
      rd_byte = irq_en_q;
    end
  end

  // captured when the wait cycle ends, held until the next read
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_readdata <= '0;
    end
    else if (bus_capture && i_read)
    begin
      o_readdata <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end
  end
endmodule // rss_regs
`default_nettype wire

/* File: sim/rss_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module rss_far_side (
  // clock
  input wire logic i_sys_clk,
  // control writes: bit 0 uart a, 1 uart b, 2 rate
  output logic [2:0] o_wr,
  output logic [7:0] o_d,
  // drive terms: chg_n, ds1_n, ds0_n, step_n
  output logic [3:0] o_drv
);
  initial
  begin
    o_wr = 3'b000;
    o_d = 8'h00;
    o_drv = 4'h0;
  end
  // data is inverted after the strobe so stale data cannot pass
  task automatic fcr(input int k, input logic [7:0] v);
    @(posedge i_sys_clk);
    o_wr[k] <= 1'b1;
    o_d <= v;
    @(posedge i_sys_clk);
    o_wr <= 3'b000;
    o_d <= ~v;
  endtask
  task automatic drv(input logic [3:0] v);
    @(posedge i_sys_clk);
    o_drv <= v;
  endtask
endmodule // rss_far_side
`default_nettype wire

/* File: sim/rss_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rss_regs_chk
  import rss_pkg::*;
(
  // clock, reset and bus
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [DATA_W-1:0] o_readdata,
  input wire logic o_waitrequest,
  // drive terms and results
  input wire logic i_head_step_strobe_n,
  input wire logic i_drive_select_zero_n,
  input wire logic i_drive_select_one_n,
  input wire logic i_disk_changed_in_n,
  input wire logic o_disk_changed_bit,
  input wire logic [1:0] o_force_change
);
  localparam logic [7:0] A_MS = {IDX_MISC_STATUS, 2'b00};
  localparam logic [7:0] A_UB = {IDX_UART_B_SHADOW, 2'b00};
  localparam logic [7:0] A_FC = {IDX_FORCE_CHANGE, 2'b00};
  localparam logic [7:0] A_RT = {IDX_RATE_SHADOW, 2'b00};
  logic rd1;
  logic fc_wr;
  logic [1:0] sw_set;
  // read request in its first cycle; data stands one cycle later
  assign rd1 = i_read && o_waitrequest;
  assign fc_wr = i_write && !o_waitrequest && i_address == A_FC;
  // a software one wins over a step clear in the same cycle
  assign sw_set = {2{fc_wr && i_byteenable[0]}} & i_writedata[1:0];
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_MISC_RSVD: assert property (
    rd1 && i_address == A_MS |=> o_readdata[7:6] == 2'b00)
    else $error("misc reserved bits nonzero");
  AST_UART_RSVD: assert property (
    rd1 && i_address == A_UB |=> o_readdata[5:4] == 2'b00)
    else $error("uart shadow reserved bits nonzero");
  AST_FORCE_RSVD: assert property (
    rd1 && i_address == A_FC |=> o_readdata[7:2] == 6'h00)
    else $error("force reserved bits nonzero");
  AST_RATE_RSVD: assert property (
    rd1 && i_address == A_RT |=> !o_readdata[5])
    else $error("rate shadow bit 5 nonzero");
  AST_STEP_CLR0: assert property (
    i_head_step_strobe_n && i_drive_select_zero_n && !sw_set[0]
    |=> !o_force_change[0])
    else $error("force flag 0 not cleared by step");
  AST_STEP_CLR1: assert property (
    i_head_step_strobe_n && i_drive_select_one_n && !sw_set[1]
    |=> !o_force_change[1])
    else $error("force flag 1 not cleared by step");
  AST_FORCE_SET: assert property (
    sw_set != 2'b00 |=> (o_force_change & $past(sw_set)) == $past(sw_set))
    else $error("force flag not set by write");
  AST_FORCE_HOLD: assert property (
    $fell(o_force_change[0])
    |-> $past(i_head_step_strobe_n) && $past(i_drive_select_zero_n))
    else $error("force flag 0 fell without step");
  AST_FORCE_HOLD1: assert property (
    $fell(o_force_change[1])
    |-> $past(i_head_step_strobe_n) && $past(i_drive_select_one_n))
    else $error("force flag 1 fell without step");
  AST_DSKCHG: assert property (
    $past(i_rst_n) |=> o_disk_changed_bit ==
      (($past(i_drive_select_zero_n) && $past(o_force_change[0])) ||
      ($past(i_drive_select_one_n) && $past(o_force_change[1])) ||
      $past(i_disk_changed_in_n)))
    else $error("disk change bit wrong");
endmodule // rss_regs_chk

bind rss_regs rss_regs_chk u_rss_regs_chk (
  .i_sys_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
  .i_byteenable, .o_readdata, .o_waitrequest, .i_head_step_strobe_n,
  .i_drive_select_zero_n, .i_drive_select_one_n, .i_disk_changed_in_n,
  .o_disk_changed_bit, .o_force_change
);
`default_nettype wire

/* File: sim/rss_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rss_regs_tb_top
  import rss_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} rss_row_s;
  localparam rss_row_s ROWS [14] = '{
    '{1'b0, 8'h70, 8'h00}, '{1'b0, 8'h74, 8'h00}, '{1'b0, 8'h78, 8'h03},
    '{1'b0, 8'h7c, 8'h02}, '{1'b0, 8'h80, 8'h00}, '{1'b0, 8'h84, 8'h00},
    '{1'b0, 8'h88, 8'h00}, '{1'b0, 8'h8c, 8'h00}, '{1'b1, 8'h74, 8'hff},
    '{1'b0, 8'h74, 8'h00}, '{1'b1, 8'h71, 8'hff}, '{1'b0, 8'h90, 8'h00},
    '{1'b1, 8'h88, 8'hff}, '{1'b0, 8'h88, 8'hff}};
  localparam logic [7:0] SH [3] = '{8'h80, 8'h74, 8'h7c};
  localparam logic [7:0] MK [3] = '{8'hcf, 8'hcf, 8'hdf};
  logic clk, rst_n, rd, wr, wreq, dsk, irq;
  logic [7:0] addr, got;
  logic [31:0] wdata, rdata;
  logic [3:0] be, drv;
  logic [5:0] pins;
  logic [2:0] fwr;
  logic [7:0] fd;
  logic [1:0] fc;
  int miscompares, samples_checked;
  rss_regs u_rss_regs (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wreq),
    .i_edge_pin_a(pins[0]), .i_edge_pin_b(pins[1]), .i_edge_pin_c(pins[2]),
    .i_edge_pin_d(pins[3]), .i_edge_pin_e(pins[4]), .i_edge_pin_f(pins[5]),
    .i_uart_a_fcr_wr(fwr[0]), .i_uart_a_fcr_data(fd),
    .i_uart_b_fcr_wr(fwr[1]), .i_uart_b_fcr_data(fd),
    .i_rate_sel_wr(fwr[2]), .i_rate_sel_data(fd),
    .i_head_step_strobe_n(drv[0]), .i_drive_select_zero_n(drv[1]),
    .i_drive_select_one_n(drv[2]), .i_disk_changed_in_n(drv[3]),
    .o_disk_changed_bit(dsk), .o_force_change(fc), .o_irq(irq));
  rss_far_side u_rss_far_side (.i_sys_clk(clk), .o_wr(fwr), .o_d(fd),
    .o_drv(drv));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask
  // waits for waitrequest low with a bound instead of a fixed latency
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata[7:0];
    if (n >= 40)
      miscompares++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    bus(1'b0, a, 8'h00, got);
    chk8("reg", e, got);
  endtask
  task automatic wt(input logic [7:0] a, d);
    bus(1'b1, a, d, got);
  endtask
  initial
  begin
    {rst_n, rd, wr, addr, wdata, be, pins} = '0;
    be = 4'h1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (ROWS[i])
    begin
      bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, got);
      if (!ROWS[i].w)
        chk8("row", ROWS[i].d, got);
    end
    for (int k = 0; k < 3; k++)
    begin
      u_rss_far_side.fcr(k, 8'hff);
      rdc(SH[k], MK[k]);
      u_rss_far_side.fcr(k, 8'h41);
      rdc(SH[k], 8'h41);
    end
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      pins[k] <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(8'h70, (8'h02 << k) - 8'h01);
    end
    chk1("irq", 1'b1, irq);
    wt(8'h70, 8'h01);
    rdc(8'h70, 8'h3e);
    wt(8'h70, 8'h00);
    rdc(8'h70, 8'h3e);
    pins[0] <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(8'h70, 8'h3f);
    wt(8'h70, 8'hff);
    rdc(8'h70, 8'h00);
    // pin edge lands on the very edge that commits the clearing write
    fork
      wt(8'h70, 8'h01);
      begin
        repeat (2) @(posedge clk);
        pins[0] <= 1'b1;
      end
    join
    rdc(8'h70, 8'h01);
    // interrupt: clear, mask, raise again
    wt(8'h8c, 8'hff);
    be <= 4'h0;
    wt(8'h88, 8'h00);
    be <= 4'h1;
    rdc(8'h88, 8'hff);
    wt(8'h88, 8'h00);
    pins[5] <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(8'h84, 8'h20);
    chk1("irq", 1'b0, irq);
    wt(8'h88, 8'hff);
    repeat (3) @(posedge clk);
    chk1("irq", 1'b1, irq);
    wt(8'h8c, 8'hff);
    repeat (3) @(posedge clk);
    chk1("irq", 1'b0, irq);
    // force flags against drive terms
    u_rss_far_side.drv(4'b0010);
    repeat (2) @(posedge clk);
    chk1("dsk", 1'b1, dsk);
    wt(8'h78, 8'h00);
    rdc(8'h78, 8'h03);
    u_rss_far_side.drv(4'b0011);
    u_rss_far_side.drv(4'b0010);
    repeat (2) @(posedge clk);
    chk8("fc", 8'h02, {6'h0, fc});
    chk1("dsk", 1'b0, dsk);
    rdc(8'h78, 8'h02);
    u_rss_far_side.drv(4'b0101);
    u_rss_far_side.drv(4'b1000);
    repeat (2) @(posedge clk);
    chk8("fc", 8'h00, {6'h0, fc});
    chk1("dsk", 1'b1, dsk);
    rdc(8'h84, 8'hc0);
    wt(8'h78, 8'h03);
    rdc(8'h78, 8'h03);
    // mid-run reset with most pins high: no false edge may follow it
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(8'h70, 8'h00);
    rdc(8'h7c, 8'h02);
    rdc(8'h78, 8'h03);
    rdc(8'h84, 8'h00);
    test_done();
  end
  initial
  begin
    #50000;
    miscompares++;
    test_done();
  end
endmodule // rss_regs_tb_top
`default_nettype wire
